// ---- hw/supply_cmd_fault_reporter.sv ----
/*
 * Fault classification and diagnostic indication for the serial
 * command path of a programmable supply, reached over APB.
 * Assumes the parser upstream writes decoded commands into REG_CMD.
 */
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module supply_cmd_fault_reporter
  import fault_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  output var  logic        fault_led,
  output var  logic        trim_mode,
  output var  logic [2:0]  diag_leds,
  output var  logic [3:0]  fault_code
);

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic        wr;
  logic        rd;
  logic        mapped;
  logic [15:0] value;
  logic [15:0] vcap;
  logic [15:0] imax;
  logic [15:0] ovp;
  logic [15:0] vout;
  logic [15:0] iout;
  logic [12:0] accum;
  logic [4:0]  cal_done;
  logic        query_seen;
  logic        cmd_go;
  logic [3:0]  cmd;
  logic [2:0]  calq;
  logic        arg_on;
  logic        flt_set;
  logic [3:0]  flt_code;
  logic        fq;
  logic [3:0]  code_q;
  logic        flag_q;
  logic [2:0]  leds_q;
  logic [7:0]  ev;

  assign wr = psel && penable && pwrite && pready;
  assign rd = psel && penable && !pwrite && pready;

  always_comb begin
    unique case (paddr)
      REG_CMD, REG_VALUE, REG_CODE, REG_STATUS,
      REG_LIMITS, REG_EVENT, REG_LEDS, REG_CALCNT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign cmd_go = wr && paddr == REG_CMD && pwdata[GO_BIT];
  assign cmd    = cmd_go ? pwdata[CMDF_LSB +: 4] : CMD_NONE;
  assign calq   = pwdata[CALQ_LSB +: 3];
  assign arg_on = pwdata[ARGON_BIT];
  assign ev     = (wr && paddr == REG_EVENT) ? pwdata[7:0] : 8'h00;
  assign fq     = cmd == CMD_FQUERY;

  // ****************************************************************
  // Fault classification
  // ****************************************************************
  always_comb begin
    flt_set  = 1'b0;
    flt_code = CODE_NONE;
    if (ev[EV_BADCHAR] || ev[EV_BADNUM] || ev[EV_BADSTR] || ev[EV_SYNTAX]) begin
      flt_set  = 1'b1;
      flt_code = CODE_SYNTAX;
    end else if (ev[EV_SLAVE]) begin
      flt_set  = 1'b1;
      flt_code = CODE_SLAVE;
    end else begin
      unique case (cmd)
        CMD_VPRG: begin
          if (value > vcap) begin
            flt_set  = 1'b1;
            flt_code = CODE_SOFTLIM;
          end
        end
        CMD_ISET: begin
          if (value > imax) begin
            flt_set  = 1'b1;
            flt_code = CODE_SOFTLIM;
          end
        end
        CMD_VCEIL: begin
          if (value < vout) begin
            flt_set  = 1'b1;
            flt_code = CODE_BADLIM;
          end
        end
        CMD_ICEIL: begin
          if (value < iout) begin
            flt_set  = 1'b1;
            flt_code = CODE_BADLIM;
          end
        end
        CMD_OVTRIP: begin
          if (value < vout) begin
            flt_set  = 1'b1;
            flt_code = CODE_OVPLOW;
          end
        end
        CMD_CAL: begin
          if (!trim_mode) begin
            flt_set  = 1'b1;
            flt_code = CODE_ILLCAL;
          end else if (calq > CAL_OVP) begin
            flt_set  = 1'b1;
            flt_code = CODE_RANGE;
          end
        end
        CMD_READ: begin
          if (!query_seen) begin
            flt_set  = 1'b1;
            flt_code = CODE_NOQUERY;
          end
        end
        CMD_NONE, CMD_TRIM, CMD_QUERY, CMD_FQUERY, CMD_RESET: ;
        default: begin
          flt_set  = cmd_go;
          flt_code = CODE_SYNTAX;
        end
      endcase
    end
  end

  fault_latch u_latch (
    .clk     (clk),
    .rst     (rst),
    .set     (flt_set),
    .code_in (flt_code),
    .query   (fq),
    .code    (code_q),
    .flag    (flag_q)
  );

  health_leds u_leds (
    .clk            (clk),
    .rst            (rst),
    .bus_timeout    (ev[EV_BUSTO]),
    .master_restart (ev[EV_MRST]),
    .slave_restart  (ev[EV_SRST]),
    .reset_cmd      (cmd == CMD_RESET),
    .leds           (leds_q)
  );

  // ****************************************************************
  // Settings held by the device
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      value <= 16'h0000;
    end else if (wr && paddr == REG_VALUE) begin
      value <= pwdata[15:0];
    end
  end

  // A violating command is ignored and leaves settings untouched.
  always_ff @(posedge clk) begin
    if (rst) begin
      vcap <= VCAP_RST;
      imax <= IMAX_RST;
      ovp  <= OVP_RST;
      vout <= 16'h0000;
      iout <= 16'h0000;
    end else if (!flt_set) begin
      if (cmd == CMD_VCEIL)  vcap <= value;
      if (cmd == CMD_ICEIL)  imax <= value;
      if (cmd == CMD_OVTRIP) ovp  <= value;
      if (cmd == CMD_VPRG)   vout <= value;
      if (cmd == CMD_ISET)   iout <= value;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      trim_mode <= 1'b0;
    end else if (cmd == CMD_TRIM) begin
      trim_mode <= arg_on;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cal_done <= 5'h00;
    end else if (cmd == CMD_CAL && !flt_set) begin
      cal_done[calq] <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      query_seen <= 1'b0;
    end else if (cmd == CMD_QUERY) begin
      query_seen <= 1'b1;
    end else if (cmd == CMD_READ) begin
      query_seen <= 1'b0;
    end
  end

  // Accumulated status: the fault bit follows the latch's flag.
  always_ff @(posedge clk) begin
    if (rst) begin
      accum <= '0;
    end else begin
      accum <= '0;
      accum[FAULT_BIT] <= flt_set || (flag_q && !fq);
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_led  <= 1'b0;
      diag_leds  <= 3'h0;
      fault_code <= CODE_NONE;
    end else begin
      fault_led  <= flag_q;
      diag_leds  <= leds_q;
      fault_code <= code_q;
    end
  end

  // One-wait slave: ready pulses in the second access-phase cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      prdata  <= 32'h0000_0000;
      if (psel && penable && !pready && !pwrite) begin
        unique case (paddr)
          REG_VALUE:  prdata <= word_of(value);
          REG_CODE:   prdata <= {28'h0, code_q};
          REG_STATUS: prdata <= {17'h0, trim_mode, query_seen,
                                 accum};
          REG_LIMITS: prdata <= {vcap, ovp};
          REG_LEDS:   prdata <= {29'h0, leds_q};
          REG_CALCNT: prdata <= {27'h0, cal_done};
          default:    prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_QUERY_CLEARS: assert property (@(posedge clk) disable iff (rst)
    fq && !flt_set |=> !flag_q && code_q == CODE_NONE)
    else $error("Fault query did not clear the flag.");

  AST_BADCHAR_CODE: assert property (@(posedge clk) disable iff (rst)
    ev[EV_BADCHAR] |=> code_q == CODE_SYNTAX)
    else $error("Bad character did not record code 4.");

  AST_SOFTLIM: assert property (@(posedge clk) disable iff (rst)
    cmd == CMD_VPRG && value > vcap && ev[4:0] == 5'h0
    |=> code_q == CODE_SOFTLIM && vout == $past(vout))
    else $error("Soft ceiling violation not handled.");

  AST_BADLIM: assert property (@(posedge clk) disable iff (rst)
    cmd == CMD_VCEIL && value < vout && ev[4:0] == 5'h0
    |=> code_q == CODE_BADLIM)
    else $error("Low ceiling not recorded as code 7.");

  AST_NOQUERY: assert property (@(posedge clk) disable iff (rst)
    cmd == CMD_READ && !query_seen && ev[4:0] == 5'h0
    |=> code_q == CODE_NOQUERY)
    else $error("Read without query not recorded.");

  AST_OVPLOW: assert property (@(posedge clk) disable iff (rst)
    cmd == CMD_OVTRIP && value < vout && ev[4:0] == 5'h0
    |=> code_q == CODE_OVPLOW)
    else $error("Low trip value not recorded as code 9.");

  AST_SLAVE: assert property (@(posedge clk) disable iff (rst)
    ev[EV_SLAVE] && ev[3:0] == 4'h0 |=> code_q == CODE_SLAVE)
    else $error("Silent slave not recorded as code 10.");

  AST_ILLCAL: assert property (@(posedge clk) disable iff (rst)
    cmd == CMD_CAL && !trim_mode && ev[4:0] == 5'h0
    |=> code_q == CODE_ILLCAL ##1 fault_code == CODE_ILLCAL)
    else $error("Calibration outside trim mode not rejected.");

  AST_FLAG_BIT: assert property (@(posedge clk) disable iff (rst)
    flt_set |=> accum[FAULT_BIT])
    else $error("Fault flag missing from status bit 7.");

  COV_QUERY: cover property (@(posedge clk) disable iff (rst)
    flag_q ##1 fq);
  COV_CAL: cover property (@(posedge clk) disable iff (rst)
    trim_mode && cmd == CMD_CAL);
  COV_LEDS: cover property (@(posedge clk) disable iff (rst)
    leds_q == 3'h7 ##1 cmd == CMD_RESET);

endmodule : supply_cmd_fault_reporter
`default_nettype wire

// ---- hw/fault_pkg.sv ----
/*
 * Constants for the supply command fault reporter: fault codes, status
 * bit positions, register offsets and decoder encodings.
 * Assumes a single 200 MHz clock and an APB master driving the registers.
 */
package fault_pkg;

  // ****************************************************************
  // Fault codes
  // ****************************************************************
  localparam logic [3:0] CODE_NONE     = 4'h0;
  localparam logic [3:0] CODE_SYNTAX   = 4'h4;
  localparam logic [3:0] CODE_RANGE    = 4'h5;
  localparam logic [3:0] CODE_SOFTLIM  = 4'h6;
  localparam logic [3:0] CODE_BADLIM   = 4'h7;
  localparam logic [3:0] CODE_NOQUERY  = 4'h8;
  localparam logic [3:0] CODE_OVPLOW   = 4'h9;
  localparam logic [3:0] CODE_SLAVE    = 4'ha;
  localparam logic [3:0] CODE_ILLCAL   = 4'hc;

  // ****************************************************************
  // Status bit positions
  // ****************************************************************
  localparam int FAULT_BIT = 7;
  localparam int STAT_W    = 13;

  // ****************************************************************
  // Command classes delivered by the parser
  // ****************************************************************
  localparam logic [3:0] CMD_NONE   = 4'h0;
  localparam logic [3:0] CMD_VPRG   = 4'h1;
  localparam logic [3:0] CMD_ISET   = 4'h2;
  localparam logic [3:0] CMD_VCEIL  = 4'h3;
  localparam logic [3:0] CMD_ICEIL  = 4'h4;
  localparam logic [3:0] CMD_OVTRIP = 4'h5;
  localparam logic [3:0] CMD_TRIM   = 4'h6;
  localparam logic [3:0] CMD_CAL    = 4'h7;
  localparam logic [3:0] CMD_QUERY  = 4'h8;
  localparam logic [3:0] CMD_READ   = 4'h9;
  localparam logic [3:0] CMD_FQUERY = 4'ha;
  localparam logic [3:0] CMD_RESET  = 4'hb;
  localparam logic [3:0] CMD_OTHER  = 4'hc;

  // ****************************************************************
  // Calibration quantities
  // ****************************************************************
  localparam logic [2:0] CAL_VPROG = 3'h0;
  localparam logic [2:0] CAL_VREAD = 3'h1;
  localparam logic [2:0] CAL_IPROG = 3'h2;
  localparam logic [2:0] CAL_IREAD = 3'h3;
  localparam logic [2:0] CAL_OVP   = 3'h4;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_VALUE  = 8'h04;
  localparam logic [7:0] REG_CODE   = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_LIMITS = 8'h10;
  localparam logic [7:0] REG_EVENT  = 8'h14;
  localparam logic [7:0] REG_LEDS   = 8'h18;
  localparam logic [7:0] REG_CALCNT = 8'h1c;

  // REG_CMD fields.
  localparam int CMDF_LSB  = 0;
  localparam int CALQ_LSB  = 4;
  localparam int ARGON_BIT = 7;
  localparam int GO_BIT    = 8;

  // REG_EVENT bits.
  localparam int EV_BADCHAR = 0;
  localparam int EV_BADNUM  = 1;
  localparam int EV_BADSTR  = 2;
  localparam int EV_SYNTAX  = 3;
  localparam int EV_SLAVE   = 4;
  localparam int EV_BUSTO   = 5;
  localparam int EV_MRST    = 6;
  localparam int EV_SRST    = 7;

  // Reset values.
  localparam logic [15:0] VCAP_RST = 16'hffff;
  localparam logic [15:0] IMAX_RST = 16'hffff;
  localparam logic [15:0] OVP_RST  = 16'hffff;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] word_of(input logic [15:0] v);
    word_of = {16'h0000, v};
  endfunction : word_of

endpackage : fault_pkg

// ---- hw/fault_latch.sv ----
/*
 * Holds the latest fault code and the fault flag.
 * Assumes at most one new code per cycle from the checker.
 */
`timescale 1ns/10ps
`default_nettype none
module fault_latch
  import fault_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       set,
  input  wire logic [3:0] code_in,
  input  wire logic       query,
  output var  logic [3:0] code,
  output var  logic       flag
);

  // Set wins over the query clear.
  always_ff @(posedge clk) begin
    if (rst) begin
      code <= CODE_NONE;
      flag <= 1'b0;
    end else if (set) begin
      code <= code_in;
      flag <= 1'b1;
    end else if (query) begin
      code <= CODE_NONE;
      flag <= 1'b0;
    end
  end

  AST_HOLD_UNTIL_READ: assert property (@(posedge clk) disable iff (rst)
    !set && !query |=> code == $past(code))
    else $error("Fault code changed without cause.");

endmodule : fault_latch
`default_nettype wire

// ---- hw/health_leds.sv ----
/*
 * Three diagnostic indicators for health monitor recovery events.
 * Assumes event inputs are single-cycle pulses.
 */
`timescale 1ns/10ps
`default_nettype none
module health_leds (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       bus_timeout,
  input  wire logic       master_restart,
  input  wire logic       slave_restart,
  input  wire logic       reset_cmd,
  output var  logic [2:0] leds
);

  logic [2:0] ev;
  assign ev = {slave_restart, master_restart, bus_timeout};

  // Each lamp is sticky; a new event beats the reset command.
  always_ff @(posedge clk) begin
    if (rst) begin
      leds <= 3'h0;
    end else begin
      leds <= ev | (reset_cmd ? 3'h0 : leds);
    end
  end

  AST_LED_CLEAR: assert property (@(posedge clk) disable iff (rst)
    reset_cmd && ev == 3'h0 |=> leds == 3'h0)
    else $error("Indicators not cleared by reset command.");

  AST_GREEN_ON: assert property (@(posedge clk) disable iff (rst)
    bus_timeout |=> leds[0])
    else $error("Green indicator missed bus timeout recovery.");

endmodule : health_leds
`default_nettype wire

// ---- test/host_model.sv ----
/*
 * Host side model: turns one request from the bench into one APB transfer.
 * Assumes the reporter answers with pready and holds no other handshake.
 */
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        go,
  input  wire logic        wr,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata,
  output var  logic        done,
  output var  logic [31:0] rdata,
  output var  logic        err
);
  // ****************************************************************
  // Transfer sequencer
  // ****************************************************************
  // Released address and data show the inverse so nothing stale passes.
  always_ff @(posedge clk) begin
    done <= 1'b0;
    if (rst) begin
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 8'h00;
      pwdata <= 32'h0;
      rdata <= 32'h0;
      err <= 1'b0;
    end else if (psel && penable && pready) begin
      psel <= 1'b0;
      penable <= 1'b0;
      rdata <= prdata;
      err <= pslverr;
      done <= 1'b1;
      paddr <= ~paddr;
      pwdata <= ~pwdata;
    end else if (psel) begin
      penable <= 1'b1;
    end else if (go) begin
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wdata;
    end
  end
endmodule : host_model
`default_nettype wire

// ---- test/supply_cmd_fault_reporter_tb.sv ----
/*
 * Self-checking bench for the supply command fault reporter.
 * Assumes the host model and the fault package are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
module supply_cmd_fault_reporter_tb
  import fault_pkg::*;
;
  logic        clk;
  logic        rst;
  logic        go;
  logic        wr;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        fault_led;
  logic        trim_mode;
  logic [2:0]  diag_leds;
  logic [3:0]  fault_code;
  logic        done;
  logic [31:0] rdata;
  logic        err;
  int          bad_count;
  int          cmp_count;

  supply_cmd_fault_reporter dut (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fault_led(fault_led), .trim_mode(trim_mode), .diag_leds(diag_leds),
    .fault_code(fault_code));

  host_model host (.clk(clk), .rst(rst), .go(go), .wr(wr), .addr(addr),
    .wdata(wdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .done(done), .rdata(rdata), .err(err));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    wr <= w;
    addr <= a;
    wdata <= d;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    while (done !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, n < 20}, 32'h1, "no bus answer");
  endtask : xfer

  function automatic logic [31:0] cw(input logic [3:0] c,
                                     input logic [2:0] q, input logic on);
    cw = {23'h0, 1'b1, on, q, c};
  endfunction : cw

  task automatic cmd(input logic [3:0] c, input logic [15:0] v);
    xfer(1'b1, REG_VALUE, {16'h0, v});
    xfer(1'b1, REG_CMD, cw(c, 3'h0, 1'b0));
  endtask : cmd

  task automatic expect_code(input logic [3:0] e);
    xfer(1'b0, REG_CODE, 32'h0);
    chk(rdata, {28'h0, e}, "held code");
    xfer(1'b0, REG_CODE, 32'h0);
    chk(rdata, {28'h0, e}, "code kept");
    chk({28'h0, fault_code}, {28'h0, e}, "code port");
    chk({31'h0, fault_led}, {31'h0, e != 4'h0}, "lamp");
    xfer(1'b0, REG_STATUS, 32'h0);
    chk({31'h0, rdata[FAULT_BIT]}, {31'h0, e != 4'h0}, "flag");
    xfer(1'b1, REG_CMD, cw(CMD_FQUERY, 3'h0, 1'b0));
    xfer(1'b0, REG_CODE, 32'h0);
    chk(rdata, 32'h0, "code after query");
    xfer(1'b0, REG_STATUS, 32'h0);
    chk({31'h0, rdata[FAULT_BIT]}, 32'h0, "flag after query");
  endtask : expect_code

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_parse;
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, REG_EVENT, 32'h1 << i);
      expect_code(CODE_SYNTAX);
    end
    xfer(1'b1, REG_CMD, cw(CMD_OTHER, 3'h0, 1'b0));
    expect_code(CODE_SYNTAX);
    xfer(1'b1, REG_EVENT, 32'h1 << EV_SLAVE);
    expect_code(CODE_SLAVE);
    $display("test parse done");
  endtask : t_parse

  task automatic t_limits;
    cmd(CMD_VPRG, 16'd100);
    expect_code(CODE_NONE);
    cmd(CMD_VCEIL, 16'd50);
    expect_code(CODE_BADLIM);
    cmd(CMD_VCEIL, 16'd150);
    cmd(CMD_VPRG, 16'd200);
    expect_code(CODE_SOFTLIM);
    cmd(CMD_VCEIL, 16'd120);
    expect_code(CODE_NONE);
    cmd(CMD_OVTRIP, 16'd50);
    expect_code(CODE_OVPLOW);
    cmd(CMD_ICEIL, 16'd10);
    cmd(CMD_ISET, 16'd20);
    expect_code(CODE_SOFTLIM);
    cmd(CMD_ISET, 16'd5);
    cmd(CMD_ICEIL, 16'd3);
    expect_code(CODE_BADLIM);
    xfer(1'b0, REG_LIMITS, 32'h0);
    chk(rdata, {16'd120, 16'hffff}, "limits kept");
    $display("test limits done");
  endtask : t_limits

  task automatic t_cal;
    xfer(1'b1, REG_CMD, cw(CMD_CAL, CAL_VPROG, 1'b0));
    expect_code(CODE_ILLCAL);
    xfer(1'b1, REG_CMD, cw(CMD_TRIM, 3'h0, 1'b1));
    chk({31'h0, trim_mode}, 32'h1, "trim on");
    for (int q = 0; q < 5; q++) begin
      xfer(1'b1, REG_CMD, cw(CMD_CAL, q[2:0], 1'b0));
    end
    expect_code(CODE_NONE);
    xfer(1'b0, REG_CALCNT, 32'h0);
    chk({27'h0, rdata[4:0]}, 32'h1f, "cal done set");
    xfer(1'b1, REG_CMD, cw(CMD_CAL, 3'h5, 1'b0));
    expect_code(CODE_RANGE);
    xfer(1'b1, REG_CMD, cw(CMD_TRIM, 3'h0, 1'b0));
    chk({31'h0, trim_mode}, 32'h0, "trim off");
    $display("test cal done");
  endtask : t_cal

  task automatic t_query;
    cmd(CMD_READ, 16'h0);
    expect_code(CODE_NOQUERY);
    cmd(CMD_QUERY, 16'h0);
    cmd(CMD_READ, 16'h0);
    expect_code(CODE_NONE);
    cmd(CMD_READ, 16'h0);
    expect_code(CODE_NOQUERY);
    $display("test query done");
  endtask : t_query

  task automatic t_leds;
    chk({29'h0, diag_leds}, 32'h0, "lamps idle");
    xfer(1'b1, REG_EVENT, 32'h1 << EV_BUSTO);
    @(posedge clk);
    chk({29'h0, diag_leds}, 32'h1, "green");
    expect_code(CODE_NONE);
    xfer(1'b1, REG_EVENT, 32'h1 << EV_MRST);
    @(posedge clk);
    chk({29'h0, diag_leds}, 32'h3, "first red");
    xfer(1'b1, REG_EVENT, 32'h1 << EV_SRST);
    @(posedge clk);
    chk({29'h0, diag_leds}, 32'h7, "second red");
    xfer(1'b0, REG_LEDS, 32'h0);
    chk(rdata, 32'h7, "lamp register");
    cmd(CMD_RESET, 16'h0);
    @(posedge clk);
    chk({29'h0, diag_leds}, 32'h0, "lamps cleared");
    $display("test leds done");
  endtask : t_leds

  task automatic t_bus;
    xfer(1'b0, 8'hfc, 32'h0);
    chk({err, rdata[30:0]}, 32'h80000000, "unmapped read");
    xfer(1'b0, REG_CODE, 32'h0);
    chk({31'h0, err}, 32'h0, "mapped read");
    $display("test bus done");
  endtask : t_bus

  // ****************************************************************
  // Clock, reset, sequence and watchdog
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    stop_test();
  end

  initial begin
    bad_count = 0;
    cmp_count = 0;
    rst = 1'b1;
    go = 1'b0;
    wr = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    expect_code(CODE_NONE);
    t_parse();
    t_limits();
    t_cal();
    t_query();
    t_leds();
    t_bus();
    stop_test();
  end
endmodule : supply_cmd_fault_reporter_tb
`default_nettype wire
